// *** design/cwt_pkg.sv ***
package cwt_pkg;
  // ----------------------------------------
  // clock and crystal timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned XTAL_MHZ_X1000 = 32_768;
  localparam int unsigned XTAL_HZ     = XTAL_MHZ_X1000;
  localparam int unsigned XTAL_DIV    = CLK_HZ / XTAL_HZ;
  localparam logic [8:0]  XTAL_DIV_LAST = 9'(XTAL_DIV - 1);

  // ----------------------------------------
  // counter and timeout scale
  // ----------------------------------------
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned BASE_SHIFT  = 9;
  localparam logic [3:0]  SCALE_MAX   = 4'h7;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR    = 8'hC0;
  localparam logic [7:0] CTRL_RESET   = 8'h10;
  localparam int unsigned SCALE_LSB   = 4;
  localparam int unsigned IRQ_MODE_BIT = 3;
  localparam int unsigned STATUS_BIT  = 2;
  localparam int unsigned REFRESH_BIT = 1;
  localparam int unsigned UNLOCK_BIT  = 0;

  typedef struct packed {
    logic [3:0] scale;
    logic       irq_mode;
    logic       status;
    logic       refresh;
    logic       unlock;
  } cwt_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cwt_sfr_req_t;

  typedef struct packed {
    cwt_ctrl_t       ctrl;
    logic [CNT_W-1:0] cnt;
    logic [8:0]      div;
    logic            irq;
    logic            sys_rst;
  } cwt_state_t;
endpackage

// *** design/cwt_watchdog.sv ***
`timescale 1ns/1ps
// What this block does
// [RULE_01] refresh bit zero stops all timeouts
// [RULE_02] missed refresh raises reset or interrupt
// [RULE_03] 16-bit counter on crystal ticks only
// [RULE_04] scale held in control bits seven to four
// [RULE_05] timeout is 512 ticks shifted by scale
// [RULE_06] scale above seven never times out
// [RULE_07] locked writes to control are ignored
// [RULE_08] interrupt mode bit picks interrupt over reset
// [RULE_09] timeout sets status flag, kept until an unlocked control write; rst loads CTRL_RESET, which clears it
// [RULE_10] unlock admits exactly the next write
// [RULE_11] refresh restarts count from zero
module cwt_watchdog (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire cwt_pkg::cwt_sfr_req_t sfr_req,
  output logic [7:0]                sfr_rdata,
  output logic                      wdt_irq,
  output logic                      wdt_sys_reset
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [cwt_pkg::CNT_W-1:0] last_tick(
    input logic [3:0] scale);
    logic [cwt_pkg::CNT_W:0] lim;
    lim = (cwt_pkg::CNT_W+1)'(1) << (cwt_pkg::BASE_SHIFT + 32'(scale));
    last_tick = cwt_pkg::CNT_W'(lim - 1'b1);
  endfunction

  cwt_pkg::cwt_state_t st_ff;
  cwt_pkg::cwt_state_t nxt_st;
  logic                tick;
  logic                hit;
  logic                ctrl_wr;

  // ----------------------------------------
  // state update
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.irq = 1'b0;
    nxt_st.sys_rst = 1'b0;
    // crystal tick divider
    tick = (st_ff.div == cwt_pkg::XTAL_DIV_LAST); // [RULE_03]
    nxt_st.div = tick ? 9'h000 : st_ff.div + 9'h001;
    // timeout compare
    hit = tick && st_ff.ctrl.refresh
          && (st_ff.ctrl.scale <= cwt_pkg::SCALE_MAX) // [RULE_06]
          && (st_ff.cnt == last_tick(st_ff.ctrl.scale)); // [RULE_05]
    ctrl_wr = sfr_req.wr && (sfr_req.addr == cwt_pkg::CTRL_ADDR);
    // count only while enabled
    if (!st_ff.ctrl.refresh) begin
      nxt_st.cnt = '0; // [RULE_01]
    end else if (hit) begin
      nxt_st.cnt = '0;
    end else if (tick) begin
      nxt_st.cnt = st_ff.cnt + 16'h0001; // [RULE_03]
    end
    // any write consumes a pending unlock
    if (sfr_req.wr) begin
      nxt_st.ctrl.unlock = 1'b0; // [RULE_10]
    end
    if (ctrl_wr) begin
      if (st_ff.ctrl.unlock) begin
        nxt_st.ctrl.scale =
          sfr_req.wdata[cwt_pkg::SCALE_LSB +: 4]; // [RULE_04]
        nxt_st.ctrl.irq_mode = sfr_req.wdata[cwt_pkg::IRQ_MODE_BIT];
        nxt_st.ctrl.status = sfr_req.wdata[cwt_pkg::STATUS_BIT];
        nxt_st.ctrl.refresh = sfr_req.wdata[cwt_pkg::REFRESH_BIT];
        if (sfr_req.wdata[cwt_pkg::REFRESH_BIT]) begin
          nxt_st.cnt = '0; // [RULE_11]
        end
      end else if (sfr_req.wdata[cwt_pkg::UNLOCK_BIT]) begin
        nxt_st.ctrl.unlock = 1'b1; // [RULE_10] [RULE_07]
      end
    end
    // timeout action, set beats software clear
    if (hit) begin
      nxt_st.ctrl.status = 1'b1; // [RULE_09] [RULE_02]
      if (st_ff.ctrl.irq_mode) begin
        nxt_st.irq = 1'b1; // [RULE_08]
      end else begin
        nxt_st.sys_rst = 1'b1; // [RULE_08]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '{ctrl: cwt_pkg::CTRL_RESET, cnt: '0, div: '0,
                 irq: 1'b0, sys_rst: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    sfr_rdata = (sfr_req.addr == cwt_pkg::CTRL_ADDR) ? st_ff.ctrl : 8'h00;
  end
  assign wdt_irq       = st_ff.irq;
  assign wdt_sys_reset = st_ff.sys_rst;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_disabled_quiet: assert property ( // [RULE_01]
    !st_ff.ctrl.refresh |=> !wdt_irq && !wdt_sys_reset)
    else $error("timeout action while disabled");
  a_timeout_flag: assert property ( // [RULE_02]
    (wdt_irq || wdt_sys_reset) |-> st_ff.ctrl.status)
    else $error("timeout without status flag");
  a_tick_count: assert property ( // [RULE_03]
    !tick && !ctrl_wr && !hit |=> $stable(st_ff.cnt))
    else $error("counter moved without crystal tick");
  a_scale_field: assert property ( // [RULE_04]
    ctrl_wr && st_ff.ctrl.unlock |=>
      st_ff.ctrl.scale == $past(sfr_req.wdata[cwt_pkg::SCALE_LSB +: 4]))
    else $error("scale field not loaded");
  a_limit_value: assert property ( // [RULE_05]
    hit |-> st_ff.cnt == last_tick(st_ff.ctrl.scale))
    else $error("timeout at wrong count");
  a_big_scale: assert property ( // [RULE_06]
    st_ff.ctrl.scale > cwt_pkg::SCALE_MAX |=> !wdt_irq && !wdt_sys_reset)
    else $error("timeout with scale above seven");
  a_locked_write: assert property ( // [RULE_07]
    ctrl_wr && !st_ff.ctrl.unlock |=>
      $stable(st_ff.ctrl.scale) && $stable(st_ff.ctrl.refresh))
    else $error("locked write changed control");
  a_mode_select: assert property ( // [RULE_08]
    hit |=> (wdt_irq == $past(st_ff.ctrl.irq_mode))
             && (wdt_sys_reset != $past(st_ff.ctrl.irq_mode)))
    else $error("wrong timeout action");
  a_flag_sticky: assert property ( // [RULE_09]
    st_ff.ctrl.status && !ctrl_wr |=> st_ff.ctrl.status)
    else $error("status flag lost");
  a_unlock_once: assert property ( // [RULE_10]
    sfr_req.wr && st_ff.ctrl.unlock |=> !st_ff.ctrl.unlock)
    else $error("unlock survived a write");
  a_refresh_restart: assert property ( // [RULE_11]
    ctrl_wr && st_ff.ctrl.unlock
      && sfr_req.wdata[cwt_pkg::REFRESH_BIT] && !hit
      |=> st_ff.cnt == '0)
    else $error("refresh did not restart count");

  // ----------------------------------------
  // checks: timeout action and counter
  // ----------------------------------------
  a_irq_pulse: assert property ( // [RULE_08]
    wdt_irq |=> !wdt_irq)
    else $error("interrupt pulse longer than one cycle");

  a_reset_pulse: assert property ( // [RULE_08]
    wdt_sys_reset |=> !wdt_sys_reset)
    else $error("reset pulse longer than one cycle");

  a_one_action: assert property ( // [RULE_08]
    !(wdt_irq && wdt_sys_reset))
    else $error("interrupt and reset together");

  a_div_bound: assert property ( // [RULE_03]
    st_ff.div <= cwt_pkg::XTAL_DIV_LAST)
    else $error("tick divider out of range");

  a_tick_wrap: assert property ( // [RULE_03]
    tick |=> st_ff.div == '0)
    else $error("tick divider did not wrap");

  a_cnt_step: assert property ( // [RULE_03]
    tick && st_ff.ctrl.refresh && !hit && !ctrl_wr
      |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
    else $error("counter did not step on tick");

  a_hit_clears: assert property ( // [RULE_05]
    hit |=> st_ff.cnt == '0)
    else $error("counter not cleared after timeout");

  a_hit_flag: assert property ( // [RULE_09]
    hit |=> st_ff.ctrl.status)
    else $error("timeout did not set status flag");

  a_off_zero: assert property ( // [RULE_01]
    !st_ff.ctrl.refresh |=> st_ff.cnt == '0)
    else $error("counter ran while disabled");

  a_off_no_hit: assert property ( // [RULE_01]
    !st_ff.ctrl.refresh |-> !hit)
    else $error("timeout compare while disabled");

  // ----------------------------------------
  // checks: register bus
  // ----------------------------------------
  a_unlock_set: assert property ( // [RULE_10]
    ctrl_wr && !st_ff.ctrl.unlock
      && sfr_req.wdata[cwt_pkg::UNLOCK_BIT] |=> st_ff.ctrl.unlock)
    else $error("unlock bit not set");

  a_unlock_hold: assert property ( // [RULE_10]
    !sfr_req.wr |=> st_ff.ctrl.unlock == $past(st_ff.ctrl.unlock))
    else $error("unlock bit moved without a write");

  a_locked_mode: assert property ( // [RULE_07]
    ctrl_wr && !st_ff.ctrl.unlock |=> $stable(st_ff.ctrl.irq_mode))
    else $error("locked write changed mode bit");

  a_mode_load: assert property ( // [RULE_07]
    ctrl_wr && st_ff.ctrl.unlock |=>
      st_ff.ctrl.irq_mode == $past(sfr_req.wdata[cwt_pkg::IRQ_MODE_BIT]))
    else $error("mode bit not loaded");

  a_refresh_load: assert property ( // [RULE_01]
    ctrl_wr && st_ff.ctrl.unlock |=>
      st_ff.ctrl.refresh == $past(sfr_req.wdata[cwt_pkg::REFRESH_BIT]))
    else $error("refresh bit not loaded");

  a_read_ctrl: assert property ( // [RULE_04]
    sfr_req.addr == cwt_pkg::CTRL_ADDR |-> sfr_rdata == st_ff.ctrl)
    else $error("read data differs from control");

endmodule

// *** dv/cwt_watchdog_tb.sv ***
`timescale 1ns/1ps
module cwt_watchdog_tb;
  // ----------------------------------------
  // clock, reset, stimulus
  // ----------------------------------------
  logic                  clock = 1'b0;
  logic                  rst = 1'b1;
  cwt_pkg::cwt_sfr_req_t req = '0;
  logic [7:0]            rdata;
  logic                  irq;
  logic                  sysr;
  logic [7:0]            exp_ctrl = 8'h10;
  logic [7:0]            rnd = 8'h37;
  int                    mismatches = 0;
  int                    tests_run = 0;

  always #50 clock = ~clock;

  cwt_watchdog u_dut (
    .clock         (clock),
    .rst           (rst),
    .sfr_req       (req),
    .sfr_rdata     (rdata),
    .wdt_irq       (irq),
    .wdt_sys_reset (sysr)
  );

  // ----------------------------------------
  // expectation helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  function automatic logic [7:0] model(input logic [7:0] c, a, d);
    if (a != cwt_pkg::CTRL_ADDR) return {c[7:1], 1'b0};
    if (c[0]) return {d[7:1], 1'b0};
    return {c[7:1], d[0]};
  endfunction

  task automatic check(input logic [7:0] e, input string what);
    tests_run++;
    if (rdata !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, rdata);
    end
  endtask

  task automatic write(input logic [7:0] a, d);
    @(negedge clock);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    exp_ctrl = model(exp_ctrl, a, d);
  endtask

  task automatic look(input logic [7:0] a, e, input string what);
    @(negedge clock);
    req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
    #1 check(e, what);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // no pulse long before the shortest interval
  // ----------------------------------------
  always @(negedge clock) begin
    if (!rst && (irq !== 1'b0 || sysr !== 1'b0)) begin
      mismatches++;
      $display("BAD early pulse expected 0 seen %b%b", irq, sysr);
    end
  end

  initial begin
    #(100 * 100000);
    mismatches++;
    complete_run;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst <= 1'b0;
    look(8'hC0, exp_ctrl, "reset value");
    write(8'hC0, 8'h72);
    look(8'hC0, exp_ctrl, "locked write");
    write(8'hC0, 8'h01);
    write(8'hC0, 8'h72);
    look(8'hC0, exp_ctrl, "unlocked write");
    write(8'hC0, 8'h01);
    write(8'h80, 8'h00);
    write(8'hC0, 8'hF6);
    look(8'hC0, exp_ctrl, "stale unlock");
    look(8'h55, 8'h00, "unmapped read");
    $display("test corner done");
    for (int i = 0; i < 300; i++) begin
      rnd = lfsr(rnd);
      write(rnd[0] ? 8'hC0 : rnd, lfsr(rnd));
      if (rnd[1]) look(8'hC0, exp_ctrl, "random write");
    end
    $display("test random done");
    complete_run;
  end
endmodule
